// ==== rtl/ars_apb.sv ====
// APB register file with sticky event status, mask and interrupt.
// Assumes APB3 master on pclk; one wait state per access.
`timescale 1ns/1ps
module ars_apb (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Sequencer side
  ars_if.regs bus
);
  import ars_pkg::*;
  typedef struct packed {
    logic [2:0] mode;
    logic hold_en;
    logic [7:0] dly1;
    logic [7:0] dly2;
    logic [7:0] hold;
    logic [4:0] dwell;
    logic [7:0] reclaim;
    logic [ARS_EV_W-1:0] stat;
    logic [ARS_EV_W-1:0] mask;
    logic lclr;
    logic ready;
    logic err;
    logic [31:0] rdata;
    logic irq;
  } ars_apb_s;
  ars_apb_s q, d;
  logic hit;
  logic [31:0] rd;
  always_comb begin
    hit = 1'b1;
    rd = '0;
    case (paddr)
      ARS_OFS_CTRL: rd = {27'h000_0000, q.hold_en, 1'b0, q.mode};
      ARS_OFS_DLY1: rd = {24'h00_0000, q.dly1};
      ARS_OFS_DLY2: rd = {24'h00_0000, q.dly2};
      ARS_OFS_HOLD: rd = {24'h00_0000, q.hold};
      ARS_OFS_DWELL: rd = {27'h000_0000, q.dwell};
      ARS_OFS_RECLAIM: rd = {24'h00_0000, q.reclaim};
      ARS_OFS_STATUS: rd = {24'h00_0000, bus.state, bus.attempt, bus.close,
                            bus.inhibit, 1'b0};
      ARS_OFS_IRQ_STAT: rd = {28'h000_0000, q.stat};
      ARS_OFS_IRQ_MASK: rd = {28'h000_0000, q.mask};
      default: hit = 1'b0;
    endcase
  end
  always_comb begin
    d = q;
    d.lclr = 1'b0;
    d.ready = psel && penable && !q.ready;
    if (d.ready) begin
      d.err = !hit;
      d.rdata = (hit && !pwrite) ? rd : '0;
    end
    d.stat = q.stat | bus.ev;
    // Write commits on the edge that completes the transfer
    if (q.ready && psel && penable && pwrite && hit) begin
      case (paddr)
        ARS_OFS_CTRL: begin
          d.mode = pwdata[2:0];
          d.hold_en = pwdata[ARS_CTRL_HOLD_BIT];
          d.lclr = pwdata[ARS_CTRL_LCLR_BIT];
        end
        ARS_OFS_DLY1: d.dly1 = pwdata[7:0];
        ARS_OFS_DLY2: d.dly2 = pwdata[7:0];
        ARS_OFS_HOLD: d.hold = pwdata[7:0];
        ARS_OFS_DWELL: d.dwell = pwdata[4:0];
        ARS_OFS_RECLAIM: d.reclaim = pwdata[7:0];
        // New events win over a clear in the same cycle
        ARS_OFS_IRQ_STAT: d.stat = (q.stat & ~pwdata[ARS_EV_W-1:0]) | bus.ev;
        ARS_OFS_IRQ_MASK: d.mask = pwdata[ARS_EV_W-1:0];
        default: d.err = q.err;
      endcase
    end
    d.irq = |(d.stat & d.mask);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.mode <= ARS_RST_MODE;
      q.dly1 <= ARS_RST_DLY1;
      q.dly2 <= ARS_RST_DLY2;
      q.hold <= ARS_RST_HOLD;
      q.dwell <= ARS_RST_DWELL;
      q.reclaim <= ARS_RST_RECLAIM;
    end else begin
      q <= d;
    end
  end
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign irq = q.irq;
  assign bus.mode = q.mode;
  assign bus.hold_en = q.hold_en;
  assign bus.dly1 = q.dly1;
  assign bus.dly2 = q.dly2;
  assign bus.hold = q.hold;
  assign bus.dwell = q.dwell;
  assign bus.reclaim = q.reclaim;
  assign bus.lock_clr = q.lclr;
endmodule // ars_apb

// ==== rtl/ars_if.sv ====
// Settings and status between the register file and the sequencer.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface ars_if;
  logic [2:0] mode;
  logic hold_en;
  logic [7:0] dly1;
  logic [7:0] dly2;
  logic [7:0] hold;
  logic [4:0] dwell;
  logic [7:0] reclaim;
  logic lock_clr;
  logic [2:0] state;
  logic [1:0] attempt;
  logic close;
  logic inhibit;
  logic [ars_pkg::ARS_EV_W-1:0] ev;
  modport regs (output mode, hold_en, dly1, dly2, hold, dwell, reclaim, lock_clr,
                input state, attempt, close, inhibit, ev);
  modport seq (input mode, hold_en, dly1, dly2, hold, dwell, reclaim, lock_clr,
               output state, attempt, close, inhibit, ev);
endinterface

// ==== rtl/ars_pkg.sv ====
// Constants, layouts and states of the autoreclose sequencer.
// Assumes a 100 MHz pclk; all timing derives from a 10 ms tick.
package ars_pkg;
  // Time base
  localparam int ARS_CLK_NS = 10;
  localparam int ARS_TICK_NS = 10_000_000;
  localparam int ARS_TICK_CYCLES = ARS_TICK_NS / ARS_CLK_NS;
  localparam int ARS_TICK_W = 20;
  // Setting units expressed in ticks
  localparam logic [15:0] ARS_TICKS_PER_100MS = 16'h000a;
  localparam logic [15:0] ARS_TICKS_PER_S = 16'h0064;
  localparam logic [4:0] ARS_DWELL_MAX = 5'h14;
  // Register byte offsets
  localparam logic [7:0] ARS_OFS_CTRL = 8'h00;
  localparam logic [7:0] ARS_OFS_DLY1 = 8'h04;
  localparam logic [7:0] ARS_OFS_DLY2 = 8'h08;
  localparam logic [7:0] ARS_OFS_HOLD = 8'h0c;
  localparam logic [7:0] ARS_OFS_DWELL = 8'h10;
  localparam logic [7:0] ARS_OFS_RECLAIM = 8'h14;
  localparam logic [7:0] ARS_OFS_STATUS = 8'h18;
  localparam logic [7:0] ARS_OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ARS_OFS_IRQ_MASK = 8'h20;
  // Control field positions
  localparam int ARS_CTRL_HOLD_BIT = 4;
  localparam int ARS_CTRL_LCLR_BIT = 8;
  // Reset values
  localparam logic [2:0] ARS_RST_MODE = 3'h0;
  localparam logic [7:0] ARS_RST_DLY1 = 8'h64;
  localparam logic [7:0] ARS_RST_DLY2 = 8'h03;
  localparam logic [7:0] ARS_RST_HOLD = 8'h01;
  localparam logic [4:0] ARS_RST_DWELL = 5'h05;
  localparam logic [7:0] ARS_RST_RECLAIM = 8'h1e;
  // Mode codes
  localparam logic [2:0] ARS_MODE_OFF = 3'h0;
  localparam logic [2:0] ARS_MODE_REACH = 3'h1;
  localparam logic [2:0] ARS_MODE_ONE = 3'h3;
  localparam logic [2:0] ARS_MODE_TWO = 3'h6;
  // Event bits
  localparam int ARS_EV_W = 4;
  localparam int ARS_EV_TRIP = 0;
  localparam int ARS_EV_CLOSE = 1;
  localparam int ARS_EV_LOCK = 2;
  localparam int ARS_EV_DONE = 3;
  typedef enum logic [2:0] {
    ARS_ST_IDLE = 3'b000,
    ARS_ST_DELAY = 3'b001,
    ARS_ST_HOLD = 3'b010,
    ARS_ST_CLOSE = 3'b011,
    ARS_ST_RECLAIM = 3'b100,
    ARS_ST_LOCK = 3'b101
  } ars_state_e;
endpackage

// ==== rtl/ars_tick.sv ====
// Divider producing a one-cycle tick every TICK_CYCLES clocks.
// Assumes a single pclk domain.
`timescale 1ns/1ps
module ars_tick #(
  parameter int TICK_CYCLES = ars_pkg::ARS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick
  output logic tick
);
  import ars_pkg::*;
  typedef struct packed {
    logic [ARS_TICK_W-1:0] cnt;
    logic tick;
  } ars_tick_s;
  ars_tick_s q, d;
  localparam logic [ARS_TICK_W-1:0] LAST = ARS_TICK_W'(TICK_CYCLES - 1);
  always_comb begin
    d = q;
    d.tick = (q.cnt == LAST);
    d.cnt = d.tick ? '0 : q.cnt + 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign tick = q.tick;
endmodule // ars_tick

// ==== rtl/ars_top.sv ====
// Automatic reclose sequencer: trip to delayed, timed breaker close.
// Assumes trip_in comes from logic on pclk; the inhibit contact is a pin.
//
// Notes on behaviour
// - Mode 0: fully disabled, all outputs inactive; irq still follows latched status and mask.
// - Mode 1: disabled, zone 1 reach reset held.
// - Mode 3: exactly one reclose attempt allowed.
// - Mode 6: two attempts, separate second delay.
// - First delay settable 0.01 to 2.55 s.
// - Second delay settable 1 to 255 s.
// - Sample inhibit before close; clear closes at once.
// - Inhibit with hold: wait, close when cleared.
// - Hold timer expires while inhibited: lockout.
// - Inhibit without hold: lockout at once.
// - Hold timer settable 1 to 255 s.
// - Close pulse lasts 0.1 to 2.0 s.
// - Reclaim wait 1 to 255 s, then reset.
// - Trip in reclaim: next attempt or lockout.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module ars_top #(
  parameter int TICK_CYCLES = ars_pkg::ARS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protection and breaker
  input wire logic trip_in,
  input wire logic inhibit_contact_converter,
  output logic close_breaker,
  output logic zone1_reach_reset_output,
  output logic lockout_active,
  // Interrupt
  output logic irq
);
  import ars_pkg::*;

  typedef struct packed {
    ars_state_e st;
    logic [1:0] att;
    logic [15:0] cnt;
    logic sync1;
    logic sync2;
    logic trip_q;
    logic close;
    logic reach;
    logic lock;
    logic [ARS_EV_W-1:0] ev;
  } ars_seq_s;

  ars_seq_s q, d;
  ars_if bus ();
  logic tick;
  logic trip_rise;
  logic enabled;
  logic [1:0] max_att;
  logic done;
  logic inhibited;
  logic [15:0] t_dly1;
  logic [15:0] t_dly2;
  logic [15:0] t_hold;
  logic [15:0] t_dwell;
  logic [15:0] t_reclaim;

  ars_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  ars_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .bus(bus.regs)
  );

  // Zero settings fall back to one unit
  function automatic logic [15:0] at_least_one(input logic [7:0] v);
    at_least_one = (v == 8'h00) ? 16'h0001 : {8'h00, v};
  endfunction

  // Settings converted to 10 ms ticks
  always_comb begin
    t_dly1 = at_least_one(bus.dly1);
    t_dly2 = at_least_one(bus.dly2) * ARS_TICKS_PER_S;
    t_hold = at_least_one(bus.hold) * ARS_TICKS_PER_S;
    if (bus.dwell > ARS_DWELL_MAX) begin
      t_dwell = {11'h000, ARS_DWELL_MAX} * ARS_TICKS_PER_100MS;
    end else begin
      t_dwell = at_least_one({3'h0, bus.dwell}) * ARS_TICKS_PER_100MS;
    end
    t_reclaim = at_least_one(bus.reclaim) * ARS_TICKS_PER_S;
  end

  // Mode decode
  always_comb begin
    enabled = 1'b0;
    max_att = 2'h0;
    case (bus.mode)
      ARS_MODE_ONE: begin
        enabled = 1'b1;
        max_att = 2'h1;
      end
      ARS_MODE_TWO: begin
        enabled = 1'b1;
        max_att = 2'h2;
      end
      default: begin
        enabled = 1'b0;
        max_att = 2'h0;
      end
    endcase
  end

  assign trip_rise = trip_in && !q.trip_q;
  assign done = (q.cnt == 16'h0000);
  assign inhibited = q.sync2;

  always_comb begin
    d = q;
    d.ev = '0;
    d.sync1 = inhibit_contact_converter;
    d.sync2 = q.sync1;
    d.trip_q = trip_in;
    if (tick && !done) begin
      d.cnt = q.cnt - 16'h0001;
    end
    case (q.st)
      ARS_ST_IDLE: begin
        if (trip_rise) begin
          d.st = ARS_ST_DELAY;
          d.att = 2'h1;
          d.cnt = t_dly1;
          d.ev[ARS_EV_TRIP] = 1'b1;
        end
      end
      ARS_ST_DELAY: begin
        if (done) begin
          if (!inhibited) begin
            d.st = ARS_ST_CLOSE;
            d.cnt = t_dwell;
            d.ev[ARS_EV_CLOSE] = 1'b1;
          end else if (bus.hold_en) begin
            d.st = ARS_ST_HOLD;
            d.cnt = t_hold;
          end else begin
            d.st = ARS_ST_LOCK;
            d.ev[ARS_EV_LOCK] = 1'b1;
          end
        end
      end
      ARS_ST_HOLD: begin
        if (!inhibited) begin
          d.st = ARS_ST_CLOSE;
          d.cnt = t_dwell;
          d.ev[ARS_EV_CLOSE] = 1'b1;
        end else if (done) begin
          d.st = ARS_ST_LOCK;
          d.ev[ARS_EV_LOCK] = 1'b1;
        end
      end
      ARS_ST_CLOSE: begin
        if (done) begin
          d.st = ARS_ST_RECLAIM;
          d.cnt = t_reclaim;
        end
      end
      ARS_ST_RECLAIM: begin
        if (trip_rise) begin
          d.ev[ARS_EV_TRIP] = 1'b1;
          if (q.att < max_att) begin
            d.st = ARS_ST_DELAY;
            d.att = q.att + 2'h1;
            d.cnt = t_dly2;
          end else begin
            d.st = ARS_ST_LOCK;
            d.ev[ARS_EV_LOCK] = 1'b1;
          end
        end else if (done) begin
          d.st = ARS_ST_IDLE;
          d.att = 2'h0;
          d.ev[ARS_EV_DONE] = 1'b1;
        end
      end
      ARS_ST_LOCK: begin
        // Left only by software or by disabling the sequencer
        if (bus.lock_clr) begin
          d.st = ARS_ST_IDLE;
          d.att = 2'h0;
        end
      end
      default: begin
        d.st = ARS_ST_IDLE;
        d.att = 2'h0;
      end
    endcase
    if (!enabled) begin
      d.st = ARS_ST_IDLE;
      d.att = 2'h0;
      d.cnt = 16'h0000;
      d.ev = '0;
    end
    d.close = (d.st == ARS_ST_CLOSE);
    d.lock = (d.st == ARS_ST_LOCK);
    d.reach = (bus.mode == ARS_MODE_REACH);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign close_breaker = q.close;
  assign zone1_reach_reset_output = q.reach;
  assign lockout_active = q.lock;
  assign bus.state = q.st;
  assign bus.attempt = q.att;
  assign bus.close = q.close;
  assign bus.inhibit = q.sync2;
  assign bus.ev = q.ev;
endmodule // ars_top

// ==== sim/ars_breaker.sv ====
// Breaker close coil and reclose inhibit contact.
// Assumes close_breaker is registered on pclk.
`timescale 1ns/1ps
module ars_breaker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Coil and contact
  input wire logic close_breaker,
  input wire logic inhibit_req,
  output logic inhibit_contact_converter,
  // Observation
  output int closes,
  output int width
);
  int run_q;
  // The contact is driven at both levels, never left floating
  assign inhibit_contact_converter = inhibit_req;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closes <= 0;
      width <= 0;
      run_q <= 0;
    end else if (close_breaker) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      closes <= closes + 1;
      width <= run_q;
      run_q <= 0;
    end
  end
endmodule // ars_breaker

// ==== sim/ars_chk_sva.sv ====
// Pin-level assertions on the reclose sequencer.
// Assumes binding to ars_top; one pclk domain, presetn async.
`timescale 1ns/1ps
module ars_chk #(
  parameter int TICK_CYCLES = ars_pkg::ARS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer pins
  input wire logic trip_in,
  input wire logic inhibit_contact_converter,
  input wire logic close_breaker,
  input wire logic zone1_reach_reset_output,
  input wire logic lockout_active,
  input wire logic irq
);
  import ars_pkg::*;
  logic [3:0] age_q;
  // Wide enough for a full close pulse at the real tick rate
  logic [31:0] cw_q;
  // Cycles since the last control write, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 4'hf;
      cw_q <= 32'h0000_0000;
    end else begin
      if (psel && penable && pready && pwrite && paddr == ARS_OFS_CTRL) begin
        age_q <= 4'h0;
      end else if (age_q != 4'hf) begin
        age_q <= age_q + 4'h1;
      end
      cw_q <= close_breaker ? cw_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  pready_ans_a: assert property (psel && penable && !pready |=> pready) else $error("no pready");
  close_min_a: assert property ($fell(close_breaker) |-> cw_q >= 9 * TICK_CYCLES)
    else $error("close pulse short");
  close_max_a: assert property (close_breaker |-> cw_q < 21 * TICK_CYCLES)
    else $error("close pulse long");
  close_lock_a: assert property (!(close_breaker && lockout_active))
    else $error("close in lockout");
  lock_exit_a: assert property ($fell(lockout_active) |-> age_q < 4'h6)
    else $error("lockout left alone");
  reach_wr_a: assert property ($changed(zone1_reach_reset_output) |-> age_q < 4'h6)
    else $error("reach reset moved alone");
  reach_close_a: assert property (zone1_reach_reset_output |-> !close_breaker)
    else $error("close with reach reset");
  inhibit_blk_a: assert property (inhibit_contact_converter [*6] |-> !$rose(close_breaker))
    else $error("close while inhibited");
  cover property ($fell(close_breaker));
  cover property ($rose(lockout_active));
  cover property ($rose(zone1_reach_reset_output));
endmodule // ars_chk

// ==== sim/breaker_autoreclose_sequencer_test.sv ====
// Self-checking bench of the reclose sequencer over APB.
// Assumes a 10-cycle tick: 1 s is 1000 pclk cycles.
`timescale 1ns/1ps
module breaker_autoreclose_sequencer_test;
  import ars_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, trip_in, inh, icc;
  logic pready, pslverr, close_breaker, zone1_reach_reset_output, lockout_active, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int mismatches, samples_checked, cyc, closes, width, k, c0;
  ars_top #(.TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trip_in(trip_in), .inhibit_contact_converter(icc),
    .close_breaker(close_breaker), .zone1_reach_reset_output(zone1_reach_reset_output),
    .lockout_active(lockout_active), .irq(irq));
  ars_breaker brk (.pclk(pclk), .presetn(presetn), .close_breaker(close_breaker),
    .inhibit_req(inh), .inhibit_contact_converter(icc), .closes(closes), .width(width));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      summarize();
    end
  end
  task summarize;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chkr(input int g, input int lo, input int hi);
    chk(32'(g >= lo && g <= hi), 32'h1);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
           output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task trip;
    trip_in <= 1'b1;
    @(posedge pclk);
    trip_in <= 1'b0;
    @(posedge pclk);
  endtask
  // Waits for close (0), lockout (1) or irq (2) to reach v
  task waitv(input int s, input logic v, input int n, output int c);
    c = 0;
    while (c < n && (s == 0 ? close_breaker : s == 1 ? lockout_active : irq) !== v) begin
      @(posedge pclk);
      c++;
    end
    chk(32'(c < n), 32'h1);
  endtask
  task t_regs;
    logic e;
    rd(ARS_OFS_CTRL, r);
    chk(r, 32'h0);
    rd(ARS_OFS_DLY1, r);
    chk(r, {24'h0, ARS_RST_DLY1});
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(ARS_OFS_DLY1, 32'h1);
    wr(ARS_OFS_DLY2, 32'h1);
    wr(ARS_OFS_HOLD, 32'h1);
    wr(ARS_OFS_DWELL, 32'h1);
    wr(ARS_OFS_RECLAIM, 32'h1);
    wr(ARS_OFS_IRQ_MASK, 32'hf);
  endtask
  task t_off;
    wr(ARS_OFS_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, zone1_reach_reset_output}, 32'h1);
    trip();
    repeat (100) @(posedge pclk);
    chk(closes, 0);
    wr(ARS_OFS_CTRL, 32'h0);
    trip();
    repeat (100) @(posedge pclk);
    chk({closes[29:0], zone1_reach_reset_output, lockout_active}, 32'h0);
  endtask
  task t_one;
    wr(ARS_OFS_CTRL, 32'h3);
    trip();
    waitv(0, 1'b1, 40, k);
    waitv(0, 1'b0, 200, k);
    @(posedge pclk);
    chkr(width, 90, 110);
    repeat (20) @(posedge pclk);
    trip();
    waitv(1, 1'b1, 20, k);
    chk(closes, 1);
    rd(ARS_OFS_IRQ_STAT, r);
    chk(r, 32'h7);
    wr(ARS_OFS_IRQ_MASK, 32'h0);
    waitv(2, 1'b0, 5, k);
    wr(ARS_OFS_IRQ_MASK, 32'hf);
    waitv(2, 1'b1, 5, k);
    wr(ARS_OFS_IRQ_STAT, 32'hf);
    waitv(2, 1'b0, 5, k);
    wr(ARS_OFS_CTRL, 32'h106);
    waitv(1, 1'b0, 10, k);
  endtask
  task t_two;
    c0 = closes;
    trip();
    waitv(0, 1'b1, 40, k);
    waitv(0, 1'b0, 200, k);
    repeat (20) @(posedge pclk);
    trip();
    waitv(0, 1'b1, 1300, k);
    chkr(k, 975, 1030);
    waitv(0, 1'b0, 200, k);
    repeat (20) @(posedge pclk);
    trip();
    waitv(1, 1'b1, 20, k);
    chk(closes - c0, 2);
  endtask
  task t_hold;
    wr(ARS_OFS_CTRL, 32'h113);
    inh <= 1'b1;
    repeat (5) @(posedge pclk);
    trip();
    repeat (200) @(posedge pclk);
    chk({31'h0, close_breaker}, 32'h0);
    inh <= 1'b0;
    waitv(0, 1'b1, 20, k);
    waitv(0, 1'b0, 200, k);
    repeat (1100) @(posedge pclk);
    rd(ARS_OFS_STATUS, r);
    chk(r & 32'he0, 32'h0);
    rd(ARS_OFS_IRQ_STAT, r);
    chk(r & 32'h8, 32'h8);
    c0 = closes;
    inh <= 1'b1;
    repeat (5) @(posedge pclk);
    trip();
    waitv(1, 1'b1, 1300, k);
    chkr(k, 950, 1100);
    chk(closes - c0, 0);
    wr(ARS_OFS_CTRL, 32'h103);
    waitv(1, 1'b0, 10, k);
    trip();
    waitv(1, 1'b1, 20, k);
    chk(closes - c0, 0);
    inh <= 1'b0;
    wr(ARS_OFS_CTRL, 32'h0);
    waitv(1, 1'b0, 10, k);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, trip_in, inh} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {mismatches, samples_checked, cyc} = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_off();
    t_one();
    t_two();
    t_hold();
    summarize();
  end
endmodule // breaker_autoreclose_sequencer_test
bind ars_top ars_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .trip_in(trip_in),
  .inhibit_contact_converter(inhibit_contact_converter), .close_breaker(close_breaker),
  .zone1_reach_reset_output(zone1_reach_reset_output), .lockout_active(lockout_active),
  .irq(irq));
